// ===== rtl/szac_pkg.sv
package szac_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int T_WR_MS = 5;
  localparam int WR_CYC_DEF = T_WR_MS * (CLK_HZ / 1000);
  localparam int CFG_BYTES = 256;
  localparam int USR_BYTES = 128;
  localparam int PAGE_BYTES = 16;
  localparam logic [4:0] AT_MAX = 5'h08;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_PW = 5'h0C;
  localparam logic [4:0] REG_CMD = 5'h10;
  localparam logic [4:0] REG_RDATA = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  // Configuration map: 00 answer-to-reset, 08 identification, 20 access control,
  // 40 issuer code, 50 cryptography, 90 secrets, B0 password sets, F0 forbidden.
  localparam logic [7:0] CFG_ACC = 8'h20;
  localparam logic [7:0] CFG_CRYPTO = 8'h50;
  localparam logic [7:0] CFG_PW = 8'hB0;
  localparam logic [7:0] CFG_FORBID = 8'hF0;
  localparam int AR_FORBID_N = 2;
  localparam int AR_WLOCK_N = 3;
  localparam int AR_ENC_N = 4;
  localparam int AR_AUTH_N = 5;
  localparam int AR_PW_RD_N = 6;
  localparam int AR_PW_WR_N = 7;
  localparam logic [7:0] NV_ERASED = 8'hFF;
  localparam logic [7:0] CNT_FULL = 8'hFF;
  localparam logic [2:0] SECURE_SET = 3'h7;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_VERIFY = 4'h3;
  localparam logic [3:0] OP_AUTH = 4'h4;
  localparam logic [3:0] OP_FUSE = 4'h5;
  localparam logic [3:0] OP_CLEAR = 4'h6;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_BUSY = 3'h1;
  localparam logic [2:0] ERR_DENIED = 3'h2;
  localparam logic [2:0] ERR_LEN = 3'h3;
  localparam logic [2:0] ERR_TRIES = 3'h4;
  localparam logic [2:0] ERR_BADPW = 3'h5;
  localparam logic [2:0] ERR_MAC = 3'h6;
  typedef enum logic [1:0] {MODE_STD, MODE_AUTH, MODE_ENC} szac_mode_t;
  typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_BUF_WR, ST_DST_WR, ST_RECOVER} szac_state_t;
  typedef struct packed {
    logic [20:0] pad;
    logic enc;
    logic rd_pw;
    logic [1:0] key;
    logic [2:0] set;
    logic [3:0] op;
  } szac_cmd_t;
  typedef struct packed {
    logic [8:0] pad;
    logic tear_pend;
    logic anti_tear;
    logic [2:0] fuses;
    logic [2:0] err;
    logic pw_wr;
    logic [2:0] pw_set;
    logic pw_valid;
    logic [1:0] key;
    szac_mode_t mode;
    logic [4:0] stage_cnt;
    logic busy;
  } szac_status_t;
endpackage

// ===== rtl/szac_zone_ctrl.sv
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module szac_zone_ctrl
  import szac_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_card_rst_n,
  input wire logic i_crypto_match,
  input wire logic i_nv_erase,
  output logic [1:0] o_mode,
  output logic o_busy
);
  localparam int TW = $clog2(WR_CYCLES + 1);
  localparam logic [TW-1:0] TMR_LOAD = TW'(WR_CYCLES - 1);

  logic ack_q, bus_acc, wr_go;
  logic [31:0] rd_q;
  logic anti_tear_q;
  logic [8:0] addr_q;
  logic [23:0] pw_cand_q;
  logic [7:0] stage_q [PAGE_BYTES];
  logic [4:0] stage_cnt_q;
  logic [7:0] cfg_mem [CFG_BYTES];
  logic [7:0] usr_mem [USR_BYTES];
  logic [7:0] nvbuf_q [PAGE_BYTES];
  logic [8:0] nv_addr_q;
  logic [4:0] nv_len_q;
  logic nv_prog_q, nv_pend_q;
  logic [2:0] fuse_q;
  szac_state_t state_q;
  logic [TW-1:0] tmr_q;
  logic [8:0] wr_addr_q;
  logic [4:0] wr_len_q;
  logic wr_prog_q, use_nv_q;
  szac_mode_t mode_q;
  logic [1:0] key_q;
  logic pw_valid_q, pw_wr_q;
  logic [2:0] pw_set_q, err_q;
  logic [7:0] rdata_q;
  logic rst_s1_q, rst_s2_q, card_rst;
  szac_cmd_t cmd;
  szac_status_t st;
  logic busy, cmd_go, cmd_busy, mac_bad, secure, is_cfg, wl, wl_ok;
  logic cfg_rd_ok, cfg_wr_ok, cfg_lock, usr_rd_ok, usr_wr_ok, common;
  logic wr_ok, rd_ok, len_bad, wr_accept, dst_commit, buf_commit;
  logic auth_ok_go, pw_hit, upd_go;
  logic [7:0] ca, ar, pr, pac_a, aac_a, password_attempt_counter, aac, upd_a, upd_d, rbyte;
  logic [6:0] ua;
  logic [4:0] wlen;
  logic [8:0] wa [PAGE_BYTES];
  logic [7:0] wd [PAGE_BYTES];

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // Every access gets exactly one wait cycle, so read data can come from a flop.
  assign bus_acc = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_acc & ~ack_q;
  assign wr_go = i_avs_write & ack_q;
  assign o_avs_readdata = rd_q;

  always_comb begin
    st = '0;
    st.busy = busy;
    st.stage_cnt = stage_cnt_q;
    st.mode = mode_q;
    st.key = key_q;
    st.pw_valid = pw_valid_q;
    st.pw_set = pw_set_q;
    st.pw_wr = pw_wr_q;
    st.err = err_q;
    st.fuses = fuse_q;
    st.anti_tear = anti_tear_q;
    st.tear_pend = nv_pend_q;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0;
    end else begin
      ack_q <= bus_acc & ~ack_q;
      if (i_avs_read & ~ack_q) begin
        case (i_avs_address)
          REG_CTRL: rd_q <= {31'h0, anti_tear_q};
          REG_ADDR: rd_q <= {23'h0, addr_q};
          REG_WDATA: rd_q <= {27'h0, stage_cnt_q};
          REG_RDATA: rd_q <= {24'h0, rdata_q};
          REG_STATUS: rd_q <= st;
          default: rd_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      anti_tear_q <= 1'b0;
      addr_q <= 9'h0;
      pw_cand_q <= 24'h0;
    end else if (wr_go) begin
      if (i_avs_address == REG_CTRL) anti_tear_q <= i_avs_writedata[0];
      if (i_avs_address == REG_ADDR) addr_q <= i_avs_writedata[8:0];
      if (i_avs_address == REG_PW) pw_cand_q <= i_avs_writedata[23:0];
    end
  end

  // Staged bytes are refused while a write runs, since the engine reads them.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage_cnt_q <= 5'h00;
    end else if ((cmd_go && cmd.op == OP_CLEAR) || (dst_commit && !use_nv_q)) begin
      stage_cnt_q <= 5'h00;
    end else if (wr_go && i_avs_address == REG_WDATA && !busy
                 && stage_cnt_q != 5'(PAGE_BYTES)) begin
      stage_cnt_q <= stage_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_go && i_avs_address == REG_WDATA && !busy && stage_cnt_q != 5'(PAGE_BYTES)) begin
      stage_q[stage_cnt_q[3:0]] <= i_avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // Card reset pin synchroniser
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
    end else begin
      rst_s1_q <= i_card_rst_n;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign card_rst = ~rst_s2_q;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  assign cmd = szac_cmd_t'(i_avs_writedata);
  assign busy = state_q != ST_IDLE;
  assign o_busy = busy;
  assign o_mode = mode_q;
  assign cmd_go = wr_go && i_avs_address == REG_CMD && !busy;
  assign cmd_busy = wr_go && i_avs_address == REG_CMD && busy;
  assign is_cfg = addr_q[8];
  assign ca = addr_q[7:0];
  assign ua = addr_q[6:0];
  assign ar = cfg_mem[CFG_ACC + {5'h0, ua[6:5], 1'b0}];
  assign pr = cfg_mem[CFG_ACC + {5'h0, ua[6:5], 1'b1}];
  assign secure = pw_valid_q && pw_wr_q && pw_set_q == SECURE_SET;
  assign mac_bad = mode_q != MODE_STD && !i_crypto_match;
  // Set 7 write code opens configuration; each fuse then freezes its span.
  assign cfg_lock = ca < CFG_ACC ? fuse_q[0] : ca < CFG_CRYPTO ? fuse_q[1] :
                    ca < CFG_PW ? fuse_q[2] : 1'b0;
  assign cfg_wr_ok = secure && ca < CFG_FORBID && !cfg_lock;
  assign cfg_rd_ok = ca < CFG_CRYPTO ? 1'b1 : ca < CFG_FORBID ?
                     secure && (ca >= CFG_PW || !fuse_q[2]) : 1'b0;
  assign common = (ar[AR_AUTH_N] || (mode_q != MODE_STD && key_q == pr[5:4]))
                  && (ar[AR_ENC_N] || mode_q == MODE_ENC);
  assign usr_rd_ok = common && (ar[AR_PW_RD_N]
                     || (pw_valid_q && pw_set_q == pr[2:0]));
  assign usr_wr_ok = common && ar[AR_FORBID_N] && (ar[AR_PW_WR_N]
                     || (pw_valid_q && pw_wr_q && pw_set_q == pr[2:0]));
  assign wl = !is_cfg && !ar[AR_WLOCK_N];
  assign wl_ok = usr_mem[{ua[6:3], 3'h0}][ua[2:0]];
  assign wlen = wl ? 5'h01 : stage_cnt_q;
  assign wr_ok = is_cfg ? cfg_wr_ok : usr_wr_ok && (!wl || wl_ok);
  assign rd_ok = is_cfg ? cfg_rd_ok : usr_rd_ok;
  assign rbyte = is_cfg ? cfg_mem[ca] : usr_mem[ua];
  assign len_bad = stage_cnt_q == 5'h00 || (anti_tear_q && stage_cnt_q > AT_MAX);
  assign wr_accept = cmd_go && cmd.op == OP_WRITE && !mac_bad && !len_bad && wr_ok;

  // Attempt counters shift in a zero per failure; all zero means exhausted.
  assign pac_a = CFG_PW + {2'h0, cmd.set, cmd.rd_pw, 2'h0};
  assign aac_a = CFG_CRYPTO + {2'h0, cmd.key, 4'h0};
  assign password_attempt_counter = cfg_mem[pac_a];
  assign aac = cfg_mem[aac_a];
  assign pw_hit = pw_cand_q == {cfg_mem[pac_a + 8'h01], cfg_mem[pac_a + 8'h02],
                                cfg_mem[pac_a + 8'h03]};
  assign auth_ok_go = cmd_go && cmd.op == OP_AUTH && aac != 8'h00 && i_crypto_match;
  always_comb begin
    upd_go = 1'b0;
    upd_a = pac_a;
    upd_d = pw_hit ? CNT_FULL : {password_attempt_counter[6:0], 1'b0};
    if (cmd_go && cmd.op == OP_VERIFY && password_attempt_counter != 8'h00) begin
      upd_go = 1'b1;
    end else if (cmd_go && cmd.op == OP_AUTH && aac != 8'h00) begin
      upd_go = 1'b1;
      upd_a = aac_a;
      upd_d = i_crypto_match ? CNT_FULL : {aac[6:0], 1'b0};
    end
  end

  // ****************************************************************
  // Write engine
  // ****************************************************************
  assign dst_commit = (state_q == ST_DST_WR || state_q == ST_RECOVER) && tmr_q == '0;
  assign buf_commit = state_q == ST_BUF_WR && tmr_q == '0;

  for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_lane
    assign wa[g] = {wr_addr_q[8:4], wr_addr_q[3:0] + 4'(g)};
    assign wd[g] = use_nv_q ? nvbuf_q[g] : stage_q[g];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_POWERUP;
      tmr_q <= '0;
      wr_addr_q <= 9'h0;
      wr_len_q <= 5'h00;
      wr_prog_q <= 1'b0;
      use_nv_q <= 1'b0;
    end else begin
      case (state_q)
        ST_POWERUP: begin
          state_q <= ST_IDLE;
          if (nv_pend_q) begin
            state_q <= ST_RECOVER;
            wr_addr_q <= nv_addr_q;
            wr_len_q <= nv_len_q;
            wr_prog_q <= nv_prog_q;
            use_nv_q <= 1'b1;
            tmr_q <= TMR_LOAD;
          end
        end
        ST_IDLE: begin
          if (wr_accept) begin
            wr_addr_q <= addr_q;
            wr_len_q <= wlen;
            wr_prog_q <= wl && ua[2:0] == 3'h0;
            use_nv_q <= anti_tear_q;
            tmr_q <= TMR_LOAD;
            state_q <= anti_tear_q ? ST_BUF_WR : ST_DST_WR;
          end
        end
        ST_BUF_WR: begin
          tmr_q <= tmr_q - TW'(1);
          if (tmr_q == '0) begin
            tmr_q <= TMR_LOAD;
            state_q <= ST_DST_WR;
          end
        end
        ST_DST_WR, ST_RECOVER: begin
          tmr_q <= tmr_q - TW'(1);
          if (tmr_q == '0) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Non-volatile storage
  // ****************************************************************
  // These flops model EEPROM and fuses, so power-up reset must not touch them.
  // Only the factory erase input blanks them.
  always_ff @(posedge i_clk) begin
    if (i_nv_erase) begin
      for (int i = 0; i < CFG_BYTES; i++) cfg_mem[i] <= NV_ERASED;
      for (int i = 0; i < USR_BYTES; i++) usr_mem[i] <= NV_ERASED;
    end else begin
      if (dst_commit) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (5'(i) < wr_len_q) begin
            if (wa[i][8]) cfg_mem[wa[i][7:0]] <= wd[i];
            else usr_mem[wa[i][6:0]] <= wr_prog_q ? usr_mem[wa[i][6:0]] & wd[i] : wd[i];
          end
        end
      end
      if (upd_go) cfg_mem[upd_a] <= upd_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_nv_erase) begin
      nv_pend_q <= 1'b0;
      fuse_q <= 3'h0;
    end else begin
      if (buf_commit) begin
        for (int i = 0; i < PAGE_BYTES; i++) nvbuf_q[i] <= stage_q[i];
        nv_addr_q <= wr_addr_q;
        nv_len_q <= wr_len_q;
        nv_prog_q <= wr_prog_q;
        nv_pend_q <= 1'b1;
      end else if (dst_commit) begin
        nv_pend_q <= 1'b0;
      end
      if (cmd_go && cmd.op == OP_FUSE && secure && cmd.key != 2'h3) begin
        fuse_q[cmd.key] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Security state
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q <= MODE_STD;
      key_q <= 2'h0;
      pw_valid_q <= 1'b0;
      pw_wr_q <= 1'b0;
      pw_set_q <= 3'h0;
      err_q <= ERR_NONE;
      rdata_q <= 8'h00;
    end else if (card_rst) begin
      mode_q <= MODE_STD;
      pw_valid_q <= 1'b0;
    end else if (cmd_busy) begin
      err_q <= ERR_BUSY;
    end else if (cmd_go) begin
      case (cmd.op)
        OP_WRITE: begin
          if (mac_bad) mode_q <= MODE_STD;
          err_q <= mac_bad ? ERR_MAC : len_bad ? ERR_LEN : !wr_ok ? ERR_DENIED : ERR_NONE;
        end
        OP_READ: begin
          rdata_q <= (rd_ok && !mac_bad) ? rbyte : 8'h00;
          if (mac_bad) mode_q <= MODE_STD;
          err_q <= mac_bad ? ERR_MAC : rd_ok ? ERR_NONE : ERR_DENIED;
        end
        OP_VERIFY: begin
          pw_valid_q <= password_attempt_counter != 8'h00 && pw_hit;
          pw_set_q <= cmd.set;
          pw_wr_q <= !cmd.rd_pw;
          err_q <= password_attempt_counter == 8'h00 ? ERR_TRIES : pw_hit ? ERR_NONE : ERR_BADPW;
        end
        OP_AUTH: begin
          mode_q <= MODE_STD;
          if (auth_ok_go) begin
            mode_q <= cmd.enc ? MODE_ENC : MODE_AUTH;
            key_q <= cmd.key;
          end
          err_q <= aac == 8'h00 ? ERR_TRIES : i_crypto_match ? ERR_NONE : ERR_BADPW;
        end
        OP_FUSE: err_q <= (secure && cmd.key != 2'h3) ? ERR_NONE : ERR_DENIED;
        OP_CLEAR: err_q <= ERR_NONE;
        default: err_q <= ERR_DENIED;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_std_until_auth;
    @(posedge i_clk) disable iff (!i_resetn)
    (mode_q == MODE_STD ##1 mode_q != MODE_STD) |-> $past(auth_ok_go);
  endproperty
  a_std_until_auth: assert property (p_std_until_auth) else $error("mode left standard");

  property p_at_len;
    @(posedge i_clk) disable iff (!i_resetn)
    (cmd_go && !card_rst && cmd.op == OP_WRITE && anti_tear_q
     && stage_cnt_q > AT_MAX && !mac_bad)
    |=> err_q == ERR_LEN && state_q == ST_IDLE;
  endproperty
  a_at_len: assert property (p_at_len) else $error("long anti-tear write taken");

  property p_buf_first;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_q == ST_IDLE && wr_accept && anti_tear_q) |=> state_q == ST_BUF_WR
    && tmr_q == TMR_LOAD;
  endproperty
  a_buf_first: assert property (p_buf_first) else $error("buffer phase skipped");

  // The phase length is checked through the timer, since it is far too long to unroll.
  property p_buf_done;
    @(posedge i_clk) disable iff (!i_resetn)
    (buf_commit && !i_nv_erase) |=> state_q == ST_DST_WR && nv_pend_q && tmr_q == TMR_LOAD;
  endproperty
  a_buf_done: assert property (p_buf_done) else $error("destination before buffer");

  property p_recover;
    @(posedge i_clk) disable iff (!i_resetn)
    (state_q == ST_POWERUP && nv_pend_q) |=> state_q == ST_RECOVER && use_nv_q;
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery at power-up");

  property p_wl_deny;
    @(posedge i_clk) disable iff (!i_resetn)
    (cmd_go && !card_rst && cmd.op == OP_WRITE && wl && !wl_ok && !mac_bad && !len_bad)
    |=> err_q == ERR_DENIED && !busy;
  endproperty
  a_wl_deny: assert property (p_wl_deny) else $error("locked byte written");

  property p_prog_only;
    @(posedge i_clk) disable iff (!i_resetn)
    (dst_commit && wr_prog_q && !i_nv_erase) |=> (usr_mem[wr_addr_q[6:0]]
    & ~$past(usr_mem[wr_addr_q[6:0]])) == 8'h00;
  endproperty
  a_prog_only: assert property (p_prog_only) else $error("control bit set");

  property p_one_byte;
    @(posedge i_clk) disable iff (!i_resetn)
    (wr_accept && wl) |=> wr_len_q == 5'h01;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("multi-byte locked write");

  property p_card_rst;
    @(posedge i_clk) disable iff (!i_resetn)
    card_rst |=> !pw_valid_q && mode_q == MODE_STD;
  endproperty
  a_card_rst: assert property (p_card_rst) else $error("privilege kept over reset");

  property p_tries;
    @(posedge i_clk) disable iff (!i_resetn)
    (cmd_go && !card_rst && cmd.op == OP_VERIFY && password_attempt_counter == 8'h00)
    |=> !pw_valid_q && err_q == ERR_TRIES;
  endproperty
  a_tries: assert property (p_tries) else $error("exhausted attempt accepted");

  property p_mac;
    @(posedge i_clk) disable iff (!i_resetn)
    (cmd_go && !card_rst && (cmd.op == OP_WRITE || cmd.op == OP_READ) && mac_bad)
    |=> mode_q == MODE_STD && err_q == ERR_MAC && !busy;
  endproperty
  a_mac: assert property (p_mac) else $error("bad MAC not revoked");
endmodule

// ===== verification/szac_crypto_model.sv
`timescale 1ns/1ps
module szac_crypto_model
  import szac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_forge,
  output logic o_crypto_match
);
  // **********************************************
  // Check engine verdict
  // **********************************************
  // The verdict is registered so that it settles one edge before the command is taken.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_crypto_match <= 1'b0;
    end else begin
      o_crypto_match <= !i_forge;
    end
  end
endmodule

// ===== verification/szac_zone_ctrl_bench.sv
`timescale 1ns/1ps
module szac_zone_ctrl_bench;
  import szac_pkg::*;
  localparam int WR = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic crst_n = 1'b1;
  logic erase = 1'b1;
  logic forge = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq;
  logic match;
  logic [1:0] mode;
  logic busy;
  szac_status_t st;
  int num_errors = 0;
  int checks_done = 0;
  int bcnt = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      bcnt++;
    end
  end
  szac_crypto_model PEER (.i_clk(clk), .i_resetn(rst_n), .i_forge(forge),
    .o_crypto_match(match));
  szac_zone_ctrl #(.WR_CYCLES(WR)) DUT (
    .i_clk(clk),
    .i_resetn(rst_n),
    .i_avs_address(adr),
    .i_avs_read(rd),
    .i_avs_write(wr),
    .i_avs_writedata(wd),
    .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq),
    .i_card_rst_n(crst_n),
    .i_crypto_match(match),
    .i_nv_erase(erase),
    .o_mode(mode),
    .o_busy(busy)
  );
  // **********************************************
  // Bus access and comparison
  // **********************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic chk_mode(input szac_mode_t e);
    checks_done++;
    if (mode !== e) begin
      num_errors++;
      $display("ERROR %0t: mode %h expected %h", $time, mode, e);
    end
  endtask
  // Called just after a rising edge; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    st = szac_status_t'(rdat);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (n >= 20) num_errors++;
  endtask
  task automatic poll();
    int n;
    n = 0;
    bus(1'b0, REG_STATUS, 32'h0);
    while (st.busy !== 1'b0 && n < 100) begin
      bus(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    if (n >= 100) num_errors++;
  endtask
  function automatic logic [31:0] mk(input logic [3:0] op, input logic [2:0] s,
    input logic [1:0] k, input logic e);
    return {21'h0, e, 1'b0, k, s, op};
  endfunction
  task automatic cmd(input logic [31:0] c);
    bus(1'b1, REG_CMD, c);
    poll();
  endtask
  task automatic vfy(input logic [2:0] s, input logic [31:0] p);
    bus(1'b1, REG_PW, p);
    cmd(mk(OP_VERIFY, s, 2'h0, 1'b0));
  endtask
  task automatic stage(input logic [8:0] a, input logic [7:0] d, input int n);
    cmd(mk(OP_CLEAR, 3'h0, 2'h0, 1'b0));
    bus(1'b1, REG_ADDR, {23'h0, a});
    for (int i = 0; i < n; i++) begin
      bus(1'b1, REG_WDATA, {24'h0, d + 8'(i)});
    end
  endtask
  task automatic wr_n(input logic [8:0] a, input logic [7:0] d, input int n);
    stage(a, d, n);
    cmd(mk(OP_WRITE, 3'h0, 2'h0, 1'b0));
  endtask
  task automatic rd_b(input logic [8:0] a);
    bus(1'b1, REG_ADDR, {23'h0, a});
    cmd(mk(OP_READ, 3'h0, 2'h0, 1'b0));
    bus(1'b0, REG_RDATA, 32'h0);
  endtask
  task automatic wrc(input logic [8:0] a, input logic [7:0] d, input int n,
    input logic [8:0] ra, input logic [7:0] e);
    wr_n(a, d, n);
    rd_b(ra);
    chk(q[7:0], e);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // **********************************************
  // Scenarios
  // **********************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    erase <= 1'b0;
    @(posedge clk);
    poll();
    chk_mode(MODE_STD);
    bus(1'b0, 5'h1C, 32'h0);
    chk(q, 32'h0);
    vfy(3'h7, 32'hFFFFFF);
    chk(st.pw_valid, 1'b1);
    wrc(9'h122, 8'hF7, 1, 9'h122, 8'hF7);
    wrc(9'h124, 8'h3F, 1, 9'h040, 8'hFF);
    wrc(9'h020, 8'hD9, 1, 9'h020, 8'hD9);
    wrc(9'h021, 8'h00, 1, 9'h021, 8'hFF);
    wrc(9'h023, 8'h3C, 1, 9'h023, 8'h3C);
    wrc(9'h026, 8'hA5, 2, 9'h027, 8'hFF);
    wrc(9'h020, 8'hFF, 1, 9'h020, 8'hD9);
    wrc(9'h020, 8'hD8, 1, 9'h020, 8'hD8);
    wrc(9'h020, 8'h00, 1, 9'h020, 8'hD8);
    cmd(mk(OP_AUTH, 3'h0, 2'h1, 1'b0));
    chk_mode(MODE_AUTH);
    cmd(mk(OP_AUTH, 3'h0, 2'h1, 1'b1));
    chk_mode(MODE_ENC);
    forge <= 1'b1;
    cmd(mk(OP_READ, 3'h0, 2'h0, 1'b0));
    forge <= 1'b0;
    chk(st.err, ERR_MAC);
    chk_mode(MODE_STD);
    cmd(mk(OP_AUTH, 3'h0, 2'h1, 1'b0));
    forge <= 1'b1;
    cmd(mk(OP_AUTH, 3'h0, 2'h1, 1'b0));
    forge <= 1'b0;
    chk_mode(MODE_STD);
    bus(1'b1, REG_CTRL, 32'h1);
    wr_n(9'h000, 8'h10, 9);
    chk(st.err, ERR_LEN);
    bcnt = 0;
    wr_n(9'h000, 8'h10, 8);
    chk(bcnt >= 2 * WR, 1'b1);
    rd_b(9'h007);
    chk(q[7:0], 8'h17);
    // Power is cut while the destination phase is under way.
    stage(9'h008, 8'h40, 8);
    bus(1'b1, REG_CMD, mk(OP_WRITE, 3'h0, 2'h0, 1'b0));
    repeat (WR + 4) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    poll();
    chk_mode(MODE_STD);
    rd_b(9'h00F);
    chk(q[7:0], 8'h47);
    vfy(3'h0, 32'hFFFFFF);
    chk(st.pw_wr, 1'b1);
    crst_n <= 1'b0;
    repeat (4) @(posedge clk);
    crst_n <= 1'b1;
    poll();
    chk(st.pw_valid, 1'b0);
    rd_b(9'h040);
    chk(q[7:0], 8'h00);
    repeat (8) vfy(3'h0, 32'h123456);
    vfy(3'h0, 32'hFFFFFF);
    chk(st.err, ERR_TRIES);
    vfy(3'h7, 32'hFFFFFF);
    chk(st.pw_set, 3'h7);
    for (int i = 0; i < 3; i++) begin
      cmd(mk(OP_FUSE, 3'h0, 2'(i), 1'b0));
    end
    chk(st.fuses, 3'h7);
    wrc(9'h122, 8'h00, 1, 9'h122, 8'hF7);
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
